// ===== logic/pbcap_pkg.sv
// constants, types and decode for the power budgeting capability registers
package pbcap_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int WORD_COUNT = 8;
    localparam logic [11:0] OFF_HEADER = 12'h280;
    localparam logic [11:0] OFF_SELECT = 12'h284;
    localparam logic [11:0] OFF_READOUT = 12'h288;
    localparam logic [11:0] OFF_ALLOC = 12'h28C;
    localparam logic [11:0] OFF_SWITCH_CTL = 12'h290;
    localparam logic [11:0] OFF_WORD_FIRST = 12'h300;
    localparam logic [11:0] OFF_WORD_LAST = 12'h31C;
    localparam int ID_LSB = 0;
    localparam int VERSION_LSB = 16;
    localparam int NEXT_PTR_LSB = 20;
    localparam int SELECT_LSB = 0;
    localparam int SYSTEM_ALLOCATED_BIT = 0;
    localparam int WORD_UNLOCK_BIT = 0;
    localparam logic [15:0] ID_RESET = 16'h0000;
    localparam logic [15:0] ID_POWER_BUDGET = 16'h0004;
    localparam logic [3:0] VERSION_RESET = 4'h0;
    localparam logic [3:0] VERSION_CURRENT = 4'h1;
    localparam logic [11:0] NEXT_PTR_END = 12'h000;
    localparam logic [7:0] SELECT_RESET = 8'h00;
    localparam logic [7:0] SELECT_LAST_WORD = 8'h07;
    localparam logic SYSTEM_ALLOCATED_RESET = 1'b0;
    localparam logic WORD_UNLOCK_RESET = 1'b0;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [11:0] next_structure_pointer;
        logic [3:0] structure_version;
        logic [15:0] structure_identifier;
    } pbcap_header_type;

    typedef enum logic [6:0] {
        REG_NONE = 7'h01,
        REG_HEADER = 7'h02,
        REG_SELECT = 7'h04,
        REG_READOUT = 7'h08,
        REG_ALLOC = 7'h10,
        REG_SWITCH_CTL = 7'h20,
        REG_WORD = 7'h40
    } pbcap_reg_type;

    function automatic pbcap_reg_type pbcap_decode(input logic [11:0] addr);
        pbcap_reg_type r;
        r = REG_NONE;
        if (addr[1:0] == 2'h0) begin
            if (addr == OFF_HEADER) r = REG_HEADER;
            else if (addr == OFF_SELECT) r = REG_SELECT;
            else if (addr == OFF_READOUT) r = REG_READOUT;
            else if (addr == OFF_ALLOC) r = REG_ALLOC;
            else if (addr == OFF_SWITCH_CTL) r = REG_SWITCH_CTL;
            else if (addr >= OFF_WORD_FIRST && addr <= OFF_WORD_LAST) r = REG_WORD;
        end
        return r;
    endfunction

    function automatic logic [31:0] pbcap_merge(input logic [31:0] old_value,
                                                input logic [31:0] new_value,
                                                input logic [3:0] strb);
        logic [31:0] m;
        m = old_value;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) m[b*8 +: 8] = new_value[b*8 +: 8];
        end
        return m;
    endfunction
endpackage

// ===== logic/pbcap_readout_mux.sv
// readout selection of one stored budget data word
`timescale 1ns/1ns
`default_nettype none
module pbcap_readout_mux #(
    parameter int WORDS = 8
) (
    // stored words and selector
    input wire logic [WORDS-1:0][31:0] words,
    input wire logic [7:0] select,
    // selected value
    output logic [31:0] data
);
    localparam int IDX_W = (WORDS > 1) ? $clog2(WORDS) : 1;

    always_comb begin
        // out-of-range selector reads zero rather than aliasing a word
        if (select < 8'(WORDS)) begin
            data = words[select[IDX_W-1:0]];
        end else begin
            data = 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// ===== logic/pbcap_regs.sv
// power budgeting capability register bank behind an AXI4-Lite slave
// Notes on behaviour
// - header identifier bits 15:0 reset zero; preload 0x4 marks power budgeting structure
// - header version bits 19:16 reset zero; loaded with 0x1 at initialisation
// - header bits 31:20 point to next structure; zero ends the list
// - select bits 7:0 read-write, reset zero, picks the word shown in readout
// - select above 7 makes the readout return zero
// - allocation flags bit 0 is lockable system-allocated flag
// - eight data words at 0x300-0x31C writable only while unlock bit set
`timescale 1ns/1ns
`default_nettype none
module pbcap_regs #(
    parameter int WORDS = pbcap_pkg::WORD_COUNT,
    parameter logic [11:0] NEXT_PTR_RESET = pbcap_pkg::NEXT_PTR_END
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address and data
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read address and data
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic aw_held_reg, w_held_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [11:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    pbcap_pkg::pbcap_header_type header_reg;
    logic [7:0] select_reg;
    logic alloc_reg;
    logic unlock_reg;
    logic [WORDS-1:0][31:0] word_mem;
    logic [31:0] readout_data;
    logic wr_fire, ar_fire;
    pbcap_pkg::pbcap_reg_type wr_target, rd_target;
    logic [2:0] wr_index;

    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign ar_fire = arvalid && arready_reg;
    assign wr_target = pbcap_pkg::pbcap_decode(aw_addr_reg);
    assign rd_target = pbcap_pkg::pbcap_decode(araddr);
    assign wr_index = aw_addr_reg[4:2];

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    // write address channel, held until the write is carried out
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
        end else if (awvalid && awready_reg) begin
            awready_reg <= 1'b0;
            aw_held_reg <= 1'b1;
            aw_addr_reg <= awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end else if (!aw_held_reg && !bvalid_reg) begin
            awready_reg <= 1'b1;
        end
    end

    // write data channel, taken independently of the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_reg <= 1'b0;
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (wvalid && wready_reg) begin
            wready_reg <= 1'b0;
            w_held_reg <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end else if (!w_held_reg && !bvalid_reg) begin
            wready_reg <= 1'b1;
        end
    end

    // write response; locked writes complete okay but are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= pbcap_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_target == pbcap_pkg::REG_NONE) ? pbcap_pkg::RESP_SLVERR
                                                            : pbcap_pkg::RESP_OKAY;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // lockable header; bus writes change it only while unlocked
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            header_reg.structure_identifier <= pbcap_pkg::ID_RESET;
            header_reg.structure_version <= pbcap_pkg::VERSION_RESET;
            header_reg.next_structure_pointer <= NEXT_PTR_RESET;
        end else if (wr_fire && unlock_reg && wr_target == pbcap_pkg::REG_HEADER) begin
            header_reg <= pbcap_pkg::pbcap_merge(header_reg, w_data_reg, w_strb_reg);
        end
    end

    // select field, always writable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            select_reg <= pbcap_pkg::SELECT_RESET;
        end else if (wr_fire && wr_target == pbcap_pkg::REG_SELECT && w_strb_reg[0]) begin
            select_reg <= w_data_reg[pbcap_pkg::SELECT_LSB +: 8];
        end
    end

    // system allocated flag, lockable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alloc_reg <= pbcap_pkg::SYSTEM_ALLOCATED_RESET;
        end else if (wr_fire && unlock_reg && wr_target == pbcap_pkg::REG_ALLOC
                     && w_strb_reg[0]) begin
            alloc_reg <= w_data_reg[pbcap_pkg::SYSTEM_ALLOCATED_BIT];
        end
    end

    // unlock bit of the switch control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unlock_reg <= pbcap_pkg::WORD_UNLOCK_RESET;
        end else if (wr_fire && wr_target == pbcap_pkg::REG_SWITCH_CTL && w_strb_reg[0]) begin
            unlock_reg <= w_data_reg[pbcap_pkg::WORD_UNLOCK_BIT];
        end
    end

    // budget data words; one reset here, so sticky means only this reset clears
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word_mem <= {WORDS{pbcap_pkg::WORD_RESET}};
        end else if (wr_fire && unlock_reg && wr_target == pbcap_pkg::REG_WORD) begin
            word_mem[wr_index] <= pbcap_pkg::pbcap_merge(word_mem[wr_index], w_data_reg,
                                                         w_strb_reg);
        end
    end

    pbcap_readout_mux #(
        .WORDS(WORDS)
    ) u_readout (
        .words(word_mem),
        .select(select_reg),
        .data(readout_data)
    );

    // read channel; answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= pbcap_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rresp_reg <= pbcap_pkg::RESP_OKAY;
            unique case (rd_target)
                pbcap_pkg::REG_HEADER: rdata_reg <= header_reg;
                pbcap_pkg::REG_SELECT: rdata_reg <= {24'h000000, select_reg};
                pbcap_pkg::REG_READOUT: rdata_reg <= readout_data;
                pbcap_pkg::REG_ALLOC: rdata_reg <= {31'h00000000, alloc_reg};
                pbcap_pkg::REG_SWITCH_CTL: rdata_reg <= {31'h00000000, unlock_reg};
                pbcap_pkg::REG_WORD: rdata_reg <= word_mem[araddr[4:2]];
                default: begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= pbcap_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg) begin
            if (rready) rvalid_reg <= 1'b0;
        end else begin
            arready_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking

    header_reset_a: assert property (!aresetn |=> header_reg.structure_identifier == 16'h0000
        && header_reg.structure_version == 4'h0) else $error("header not cleared by reset");
    header_lock_a: assert property (disable iff (!aresetn)
        wr_fire && !unlock_reg |=> $stable(header_reg)) else $error("locked header changed");
    select_write_a: assert property (disable iff (!aresetn)
        wr_fire && wr_target == pbcap_pkg::REG_SELECT && w_strb_reg[0]
        |=> select_reg == $past(w_data_reg[7:0])) else $error("select not updated");
    readout_zero_a: assert property (disable iff (!aresetn)
        ar_fire && rd_target == pbcap_pkg::REG_READOUT && select_reg > 8'h07
        |=> rvalid_reg && rdata_reg == 32'h0000_0000) else $error("readout not zero");
    readout_word_a: assert property (disable iff (!aresetn)
        ar_fire && rd_target == pbcap_pkg::REG_READOUT && select_reg <= 8'h07
        |=> rdata_reg == $past(word_mem[select_reg[2:0]])) else $error("readout wrong word");
    alloc_lock_a: assert property (disable iff (!aresetn)
        wr_fire && !unlock_reg |=> $stable(alloc_reg)) else $error("locked flag changed");
    word_lock_a: assert property (disable iff (!aresetn)
        wr_fire && !unlock_reg |=> $stable(word_mem)) else $error("locked word changed");
    word_write_a: assert property (disable iff (!aresetn)
        wr_fire && unlock_reg && wr_target == pbcap_pkg::REG_WORD && w_strb_reg == 4'hF
        |=> word_mem[$past(wr_index)] == $past(w_data_reg)) else $error("word not written");
    // readout must already read zero when the write response rises after a select write above SELECT_LAST_WORD
    select_to_read_a: assert property (disable iff (!aresetn)
        wr_fire && wr_target == pbcap_pkg::REG_SELECT && w_strb_reg[0]
        && w_data_reg[7:0] > pbcap_pkg::SELECT_LAST_WORD
        |=> readout_data == 32'h0000_0000) else $error("readout lags select");

    unlocked_word_c: cover property (wr_fire && unlock_reg && wr_target == pbcap_pkg::REG_WORD);
    locked_word_c: cover property (wr_fire && !unlock_reg && wr_target == pbcap_pkg::REG_WORD);
    readout_high_c: cover property (ar_fire && rd_target == pbcap_pkg::REG_READOUT
                                    && select_reg > 8'h07);
    unmapped_c: cover property (ar_fire && rd_target == pbcap_pkg::REG_NONE);
endmodule
`default_nettype wire

// ===== testbench/pbcap_regs_tb.sv
// self-checking bench for the power budgeting capability register bank
`timescale 1ns/1ns
`default_nettype none
module pbcap_regs_tb;
    logic aclk;
    logic aresetn;
    logic [11:0] awaddr;
    logic [11:0] araddr;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [3:0] strb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] words [8];
    logic [31:0] exp_rd [$];
    logic [1:0] exp_rr [$];
    logic [1:0] exp_br [$];
    int bad_count = 0;
    int total_checks = 0;
    localparam logic [1:0] OK = pbcap_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = pbcap_pkg::RESP_SLVERR;

    pbcap_regs pbcap_regs_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask

    // values seen at the handshake edge are the pre-edge outputs
    always @(posedge aclk) begin
        if (aresetn === 1'b1 && bvalid === 1'b1 && bready === 1'b1) begin
            if (exp_br.size() == 0) chk("stray bresp", 32'h1, 32'h0);
            else chk("bresp", 32'(exp_br.pop_front()), 32'(bresp));
        end
        if (aresetn === 1'b1 && rvalid === 1'b1 && rready === 1'b1) begin
            if (exp_rd.size() == 0) chk("stray rvalid", 32'h1, 32'h0);
            else begin
                chk("rdata", exp_rd.pop_front(), rdata);
                chk("rresp", 32'(exp_rr.pop_front()), 32'(rresp));
            end
        end
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        logic aw_left, w_left;
        exp_br.push_back(e);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_left = 1'b1;
        w_left = 1'b1;
        n = 0;
        forever begin
            @(posedge aclk);
            n++;
            if (aw_left && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_left = 1'b0;
            end
            if (w_left && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_left = 1'b0;
            end
            if (bvalid === 1'b1) break;
            if (n > 100) begin
                bad_count++;
                complete_run();
            end
        end
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        exp_rd.push_back(d);
        exp_rr.push_back(e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        forever begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
            if (n > 100) begin
                bad_count++;
                complete_run();
            end
        end
        rready <= 1'b0;
    endtask

    initial begin
        logic [7:0] s;
        aresetn = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        void'($urandom(32'h25D1));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(pbcap_pkg::OFF_HEADER, 32'h0000_0000, OK);
        rd(pbcap_pkg::OFF_SELECT, 32'h0000_0000, OK);
        rd(pbcap_pkg::OFF_READOUT, 32'h0000_0000, OK);
        rd(pbcap_pkg::OFF_ALLOC, 32'h0000_0000, OK);
        $display("test reset values done");
        // locked: lockable fields and data words ignore writes
        wr(pbcap_pkg::OFF_HEADER, 32'h0001_0004, OK);
        wr(pbcap_pkg::OFF_ALLOC, 32'h0000_0001, OK);
        wr(pbcap_pkg::OFF_WORD_FIRST, 32'hA5A5_0001, OK);
        rd(pbcap_pkg::OFF_HEADER, 32'h0000_0000, OK);
        rd(pbcap_pkg::OFF_ALLOC, 32'h0000_0000, OK);
        rd(pbcap_pkg::OFF_WORD_FIRST, 32'h0000_0000, OK);
        $display("test locked writes done");
        wr(pbcap_pkg::OFF_SWITCH_CTL, 32'h0000_0001, OK);
        wr(pbcap_pkg::OFF_HEADER, 32'h3201_0004, OK);
        rd(pbcap_pkg::OFF_HEADER, 32'h3201_0004, OK);
        wr(pbcap_pkg::OFF_HEADER, 32'h0001_0004, OK);
        rd(pbcap_pkg::OFF_HEADER, 32'h0001_0004, OK);
        wr(pbcap_pkg::OFF_ALLOC, 32'hFFFF_FFFF, OK);
        rd(pbcap_pkg::OFF_ALLOC, 32'h0000_0001, OK);
        for (int i = 0; i < 8; i++) begin
            words[i] = $urandom;
            wr(pbcap_pkg::OFF_WORD_FIRST + 12'(4 * i), words[i], OK);
        end
        for (int i = 0; i < 8; i++) rd(pbcap_pkg::OFF_WORD_FIRST + 12'(4 * i), words[i], OK);
        // partial strobe: only the two low bytes of the last word change
        strb = 4'h3;
        wr(pbcap_pkg::OFF_WORD_LAST, 32'h0000_0000, OK);
        strb = 4'hF;
        words[7][15:0] = 16'h0000;
        rd(pbcap_pkg::OFF_WORD_LAST, words[7], OK);
        // readout one idle cycle after each select write response
        for (int i = 7; i >= 0; i--) begin
            wr(pbcap_pkg::OFF_SELECT, 32'hFFFF_FF00 | 32'(i), OK);
            rd(pbcap_pkg::OFF_READOUT, words[i], OK);
        end
        wr(pbcap_pkg::OFF_SELECT, 32'hFFFF_FF08, OK);
        rd(pbcap_pkg::OFF_SELECT, 32'h0000_0008, OK);
        rd(pbcap_pkg::OFF_READOUT, 32'h0000_0000, OK);
        s = 8'($urandom_range(255, 9));
        wr(pbcap_pkg::OFF_SELECT, 32'(s), OK);
        rd(pbcap_pkg::OFF_READOUT, 32'h0000_0000, OK);
        $display("test unlocked select and readout done");
        wr(pbcap_pkg::OFF_SWITCH_CTL, 32'h0000_0000, OK);
        wr(pbcap_pkg::OFF_WORD_FIRST + 12'h00C, ~words[3], OK);
        wr(pbcap_pkg::OFF_SELECT, 32'h0000_0003, OK);
        rd(pbcap_pkg::OFF_READOUT, words[3], OK);
        wr(pbcap_pkg::OFF_READOUT, 32'h1234_5678, OK);
        rd(pbcap_pkg::OFF_READOUT, words[3], OK);
        rd(12'h200, 32'h0000_0000, ERR);
        wr(12'h200, 32'hFFFF_FFFF, ERR);
        rd(12'h281, 32'h0000_0000, ERR);
        $display("test relock and refusals done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(pbcap_pkg::OFF_SELECT, 32'h0000_0000, OK);
        rd(pbcap_pkg::OFF_HEADER, 32'h0000_0000, OK);
        rd(pbcap_pkg::OFF_ALLOC, 32'h0000_0000, OK);
        $display("test second reset done");
        repeat (4) @(posedge aclk);
        if (exp_rd.size() != 0 || exp_br.size() != 0) bad_count++;
        complete_run();
    end
endmodule
`default_nettype wire
